//--- logic/backup_domain_counter.sv
/*
 * backup-domain counter register block: control, counter, compare, stamp,
 * crystal failure detect, status and retention ram power-down.
 * assumes oscillator ticks arrive as one-cycle enables synchronous to core_clk.
 */
// Local design decision: the plain strobed port.
`timescale 1ns/100ps
module backup_domain_counter
   import rtc_regs_pkg::*;
#(
   parameter int CNT_W = 32
) (
   input  wire logic        core_clk,
   input  wire logic        rst_n,
   input  wire logic [7:0]  addr,
   input  wire logic [31:0] wdata,
   input  wire logic        wr_en,
   input  wire logic        rd_en,
   output logic      [31:0] rdata,
   input  wire logic        rc_tick,
   input  wire logic        xtal_tick,
   input  wire logic        ulf_tick,
   input  wire logic        debug_halt,
   input  wire logic        backup_mode,
   input  wire logic        ram_write_busy,
   input  wire logic [2:0]  energy_mode,
   output logic             osc_keep_em3,
   output logic             osc_keep_em4,
   output logic             compare_pulse,
   output logic             overflow_pulse,
   output logic             crystal_failure_flag,
   output logic             ram_powered_down
);
   if (CNT_W != 32) begin : g_width_check
      $error("counter width must be 32");
   end

   logic [14:0] ctrl_q;
   logic [1:0]  lpcfg_q;
   logic [31:0] cnt_q;
   logic [31:0] comp_q;
   logic [31:0] stamp_q;
   logic [8:0]  fdet_q;
   logic        retention_write_error_q;
   logic        stamped_q;
   logic        pdown_q;
   logic [4:0]  fd_cnt_q;
   logic        xtal_seen_q;
   logic        fd_armed_q;
   logic        fail_q;
   logic [6:0]  div_q;
   logic        bu_q;
   logic [1:0]  stamp_wait_q;
   logic        cmp_q;
   logic        of_q;

   wire wr_ctrl  = wr_en && addr == OFF_CTRL;
   wire wr_lpcfg = wr_en && addr == OFF_LPCFG;
   wire wr_comp  = wr_en && addr == OFF_COMP;
   wire wr_fdet  = wr_en && addr == OFF_FDET;
   wire wr_pdown = wr_en && addr == OFF_PDOWN;
   wire clr_stat = wr_en && addr == OFF_CMD && wdata[0];

   wire       hold    = ctrl_q[CTRL_HOLD];
   wire [2:0] div_exp = ctrl_q[CTRL_DIV_HI:CTRL_DIV_LO];
   wire [2:0] lpc     = ctrl_q[CTRL_LPC_HI:CTRL_LPC_LO];
   clk_sel_t  csel;
   run_mode_t mode;
   assign csel = clk_sel_t'(ctrl_q[CTRL_CLK_HI:CTRL_CLK_LO]);
   assign mode = run_mode_t'(ctrl_q[CTRL_MODE_HI:0]);

   // register writes, reserved bits dropped
   always_ff @(posedge core_clk or negedge rst_n) begin
      if (!rst_n) begin
         ctrl_q  <= CTRL_RESET;
         lpcfg_q <= 2'h0;
         comp_q  <= 32'h00000000;
         fdet_q  <= 9'h000;
      end else begin
         if (wr_ctrl) ctrl_q <= wdata[14:0] & CTRL_MASK;
         if (wr_lpcfg) lpcfg_q <= wdata[1:0];
         if (wr_comp) comp_q <= wdata;
         if (wr_fdet) fdet_q <= wdata[8:0] & FDET_MASK[8:0];
      end
   end

   // power-down is one-way
   always_ff @(posedge core_clk or negedge rst_n) begin
      if (!rst_n) pdown_q <= 1'b0;
      else if (wr_pdown && wdata[0]) pdown_q <= 1'b1;
   end
   assign ram_powered_down = pdown_q;

   // crystal failure detect down counter
   fd_sel_t fsel;
   assign fsel = fd_sel_t'(fdet_q[1:0]);
   wire fd_tick = (fsel == FD_RC) ? rc_tick : (fsel == FD_ULF) ? ulf_tick : 1'b0;
   always_ff @(posedge core_clk or negedge rst_n) begin
      if (!rst_n) begin
         fd_cnt_q    <= 5'h00;
         xtal_seen_q <= 1'b0;
         fd_armed_q  <= 1'b0;
         fail_q      <= 1'b0;
      end else if (fsel == FD_OFF || fsel == 2'b11) begin
         xtal_seen_q <= 1'b0;
         fd_armed_q  <= 1'b0;
         fd_cnt_q    <= fdet_q[FDET_TOP_HI:FDET_TOP_LO];
      end else begin
         if (fd_tick) begin
            if (fd_cnt_q == 5'h00) begin
               fd_cnt_q <= fdet_q[FDET_TOP_HI:FDET_TOP_LO];
               // judged only from the second zero crossing on
               fd_armed_q <= 1'b1;
               if (fd_armed_q && !xtal_seen_q && !xtal_tick) fail_q <= 1'b1;
               xtal_seen_q <= 1'b0;
            end else begin
               fd_cnt_q <= fd_cnt_q - 5'h01;
               if (xtal_tick) xtal_seen_q <= 1'b1;
            end
         end else if (xtal_tick) begin
            xtal_seen_q <= 1'b1;
         end
      end
   end
   assign crystal_failure_flag = fail_q;

   // source selection, falls back to the reference after failure
   logic src_tick;
   always_comb begin
      src_tick = 1'b0;
      if (csel == CLK_XTAL && fail_q) src_tick = (fsel == FD_ULF) ? ulf_tick : rc_tick;
      else begin
         case (csel)
            CLK_NONE: src_tick = 1'b0;
            CLK_RC:   src_tick = rc_tick;
            CLK_XTAL: src_tick = xtal_tick;
            CLK_ULF:  src_tick = ulf_tick;
            default:  src_tick = 1'b0;
         endcase
      end
   end

   // energy-mode gating
   logic mode_run;
   always_comb begin
      case (mode)
         MODE_OFF: mode_run = 1'b0;
         MODE_EM2: mode_run = energy_mode <= 3'h2;
         MODE_EM3: mode_run = energy_mode <= 3'h3;
         MODE_EM4: mode_run = energy_mode <= 3'h4;
         default:  mode_run = 1'b0;
      endcase
   end
   assign osc_keep_em3 = mode == MODE_EM3 || mode == MODE_EM4;
   assign osc_keep_em4 = mode == MODE_EM4;

   wire run = mode_run && !hold && (!debug_halt || ctrl_q[CTRL_DBG]);

   // prescaler
   always_ff @(posedge core_clk or negedge rst_n) begin
      if (!rst_n) div_q <= 7'h00;
      else if (hold) div_q <= 7'h00;
      else if (run && src_tick) div_q <= div_q + 7'h01;
   end
   wire [6:0] div_mask = 7'((8'h01 << div_exp) - 8'h01);
   wire cnt_tick = run && src_tick && ((div_q & div_mask) == div_mask);

   // low power state
   logic lp_act;
   always_comb begin
      case (lp_sel_t'(lpcfg_q))
         LP_ON:     lp_act = 1'b1;
         LP_BACKUP: lp_act = backup_mode;
         default:   lp_act = 1'b0;
      endcase
   end
   wire [31:0] ign   = lp_act ? 32'((33'h1 << lpc) - 33'h1) : 32'h0;
   wire        match = ((cnt_q ^ comp_q) & ~ign) == 32'h0;
   wire        wrap  = ctrl_q[CTRL_WRAP] && cnt_q == comp_q;

   // counter
   always_ff @(posedge core_clk or negedge rst_n) begin
      if (!rst_n) cnt_q <= 32'h00000000;
      else if (hold) cnt_q <= 32'h00000000;
      else if (cnt_tick) begin
         if (wrap) cnt_q <= 32'h00000000;
         else cnt_q <= cnt_q + 32'h1;
      end
   end

   // compare and overflow events
   always_ff @(posedge core_clk or negedge rst_n) begin
      if (!rst_n) begin
         cmp_q <= 1'b0;
         of_q  <= 1'b0;
      end else begin
         cmp_q <= cnt_tick && match;
         of_q  <= cnt_tick && !ctrl_q[CTRL_WRAP] && cnt_q == 32'hFFFFFFFF;
      end
   end
   assign compare_pulse  = cmp_q;
   assign overflow_pulse = of_q;

   // backup entry stamp, two source clock ticks later, before the prescaler
   wire bu_rise = backup_mode && !bu_q;
   always_ff @(posedge core_clk or negedge rst_n) begin
      if (!rst_n) begin
         bu_q         <= 1'b0;
         stamp_wait_q <= 2'h0;
      end else begin
         bu_q <= backup_mode;
         if (hold) stamp_wait_q <= 2'h0;
         else if (bu_rise && ctrl_q[CTRL_STAMP_EN] && !stamped_q)
            stamp_wait_q <= 2'(STAMP_DELAY);
         else if (stamp_wait_q != 2'h0 && src_tick) stamp_wait_q <= stamp_wait_q - 2'h1;
      end
   end
   wire stamp_now = stamp_wait_q == 2'h1 && src_tick && !hold;

   always_ff @(posedge core_clk or negedge rst_n) begin
      if (!rst_n) stamp_q <= 32'h00000000;
      else if (hold) stamp_q <= 32'h00000000;
      else if (stamp_now) stamp_q <= cnt_q & ~ign;
   end

   // sticky status, set wins over clear
   always_ff @(posedge core_clk or negedge rst_n) begin
      if (!rst_n) begin
         stamped_q <= 1'b0;
         retention_write_error_q <= 1'b0;
      end else begin
         if (stamp_now) stamped_q <= 1'b1;
         else if (clr_stat) stamped_q <= 1'b0;
         if (bu_rise && ram_write_busy) retention_write_error_q <= 1'b1;
         else if (clr_stat) retention_write_error_q <= 1'b0;
      end
   end

   // read port, one cycle latency
   always_ff @(posedge core_clk or negedge rst_n) begin
      if (!rst_n) rdata <= 32'h00000000;
      else if (rd_en) begin
         if (addr == OFF_CTRL) rdata <= {17'h0, ctrl_q};
         else if (addr == OFF_LPCFG) rdata <= {30'h0, lpcfg_q};
         else if (addr == OFF_CNT) rdata <= cnt_q;
         else if (addr == OFF_COMP) rdata <= comp_q;
         else if (addr == OFF_STAMP) rdata <= stamp_q;
         else if (addr == OFF_FDET) rdata <= {23'h0, fdet_q};
         else if (addr == OFF_STATUS) rdata <= {29'h0, retention_write_error_q, stamped_q, lp_act};
         else if (addr == OFF_PDOWN) rdata <= {31'h0, pdown_q};
         else if (addr == OFF_EVENTS) rdata <= {31'h0, fail_q};
         else rdata <= 32'h00000000;
      end
   end

   hold_clears_a: assert property (@(posedge core_clk) disable iff (!rst_n)
      hold |=> cnt_q == 32'h0 && stamp_q == 32'h0)
      else $error("counter not held");
   wrap_zero_a: assert property (@(posedge core_clk) disable iff (!rst_n)
      cnt_tick && wrap && !hold |=> cnt_q == 32'h0)
      else $error("no wrap at compare");
   count_step_a: assert property (@(posedge core_clk) disable iff (!rst_n)
      !cnt_tick && !hold |=> $stable(cnt_q))
      else $error("counter moved without tick");
   halt_freeze_a: assert property (@(posedge core_clk) disable iff (!rst_n)
      debug_halt && !ctrl_q[CTRL_DBG] && !hold |=> $stable(cnt_q))
      else $error("counter ran in halt");
   pdown_sticky_a: assert property (@(posedge core_clk) disable iff (!rst_n)
      pdown_q |=> pdown_q)
      else $error("ram powered up again");
   stamp_flag_a: assert property (@(posedge core_clk) disable iff (!rst_n)
      stamp_now |=> stamped_q && stamp_q == ($past(cnt_q) & ~$past(ign)))
      else $error("stamp not stored");
   clear_stat_a: assert property (@(posedge core_clk) disable iff (!rst_n)
      clr_stat && !stamp_now && !(bu_rise && ram_write_busy) |=> !stamped_q && !retention_write_error_q)
      else $error("status not cleared");
   ramerr_set_a: assert property (@(posedge core_clk) disable iff (!rst_n)
      bu_rise && ram_write_busy |=> retention_write_error_q)
      else $error("ram write error missed");
   off_mode_a: assert property (@(posedge core_clk) disable iff (!rst_n)
      mode == MODE_OFF |-> !cnt_tick)
      else $error("counter ran while disabled");
   overflow_wrap_a: assert property (@(posedge core_clk) disable iff (!rst_n)
      overflow_pulse |-> $past(cnt_q) == 32'hFFFFFFFF && cnt_q == 32'h0)
      else $error("overflow without wrap");
endmodule

//--- shared/rtc_regs_pkg.sv
/*
 * constants for the backup-domain counter register block: offsets, fields, resets.
 * assumes a plain strobe register port and one core clock at 25 MHz.
 */
package rtc_regs_pkg;
   localparam logic [7:0] OFF_CTRL   = 8'h00;
   localparam logic [7:0] OFF_LPCFG  = 8'h04;
   localparam logic [7:0] OFF_CNT    = 8'h08;
   localparam logic [7:0] OFF_COMP   = 8'h0C;
   localparam logic [7:0] OFF_STAMP  = 8'h10;
   localparam logic [7:0] OFF_FDET   = 8'h14;
   localparam logic [7:0] OFF_STATUS = 8'h18;
   localparam logic [7:0] OFF_CMD    = 8'h1C;
   localparam logic [7:0] OFF_PDOWN  = 8'h20;
   localparam logic [7:0] OFF_EVENTS = 8'h40;

   localparam int CTRL_STAMP_EN = 14;
   localparam int CTRL_CLK_HI   = 13;
   localparam int CTRL_CLK_LO   = 12;
   localparam int CTRL_DIV_HI   = 10;
   localparam int CTRL_DIV_LO   = 8;
   localparam int CTRL_LPC_HI   = 7;
   localparam int CTRL_LPC_LO   = 5;
   localparam int CTRL_WRAP     = 4;
   localparam int CTRL_HOLD     = 3;
   localparam int CTRL_DBG      = 2;
   localparam int CTRL_MODE_HI  = 1;
   localparam logic [14:0] CTRL_RESET = 15'h0008;
   localparam logic [14:0] CTRL_MASK  = 15'h77FF;

   localparam int FDET_TOP_HI = 8;
   localparam int FDET_TOP_LO = 4;
   localparam logic [31:0] FDET_MASK = 32'h000001F3;

   localparam int ST_RETENTION_WRITE_ERROR = 2;
   localparam int ST_STAMPED = 1;
   localparam int ST_LPACT   = 0;

   localparam int STAMP_DELAY = 2;

   typedef enum logic [1:0] {
      CLK_NONE = 2'b00, CLK_RC = 2'b01, CLK_XTAL = 2'b10, CLK_ULF = 2'b11
   } clk_sel_t;
   typedef enum logic [1:0] {
      MODE_OFF = 2'b00, MODE_EM2 = 2'b01, MODE_EM3 = 2'b10, MODE_EM4 = 2'b11
   } run_mode_t;
   typedef enum logic [1:0] {
      LP_OFF = 2'b00, LP_ON = 2'b01, LP_BACKUP = 2'b10
   } lp_sel_t;
   typedef enum logic [1:0] {
      FD_OFF = 2'b00, FD_RC = 2'b01, FD_ULF = 2'b10
   } fd_sel_t;
endpackage

//--- sim/tb.sv
/*
 * self-checking bench for the backup-domain counter register block.
 * assumes the design's strobe register port and one 25 MHz core clock.
 */
`timescale 1ns/100ps
module tb;
   import rtc_regs_pkg::*;
   logic        core_clk;
   logic        rst_n;
   logic [7:0]  addr;
   logic [31:0] wdata;
   logic        wr_en;
   logic        rd_en;
   logic [31:0] rdata;
   logic        rc_tick;
   logic        xtal_tick;
   logic        ulf_tick;
   logic        debug_halt;
   logic        backup_mode;
   logic        ram_write_busy;
   logic [2:0]  energy_mode;
   logic        osc_keep_em3;
   logic        osc_keep_em4;
   logic        compare_pulse;
   logic        overflow_pulse;
   logic        crystal_failure_flag;
   logic        ram_powered_down;
   int          n_fail;
   int          samples_checked;
   int          n_cmp;
   int          n_of;
   logic [31:0] v;

   backup_domain_counter uut (
      .core_clk(core_clk), .rst_n(rst_n), .addr(addr), .wdata(wdata),
      .wr_en(wr_en), .rd_en(rd_en), .rdata(rdata), .rc_tick(rc_tick),
      .xtal_tick(xtal_tick), .ulf_tick(ulf_tick), .debug_halt(debug_halt),
      .backup_mode(backup_mode), .ram_write_busy(ram_write_busy),
      .energy_mode(energy_mode), .osc_keep_em3(osc_keep_em3),
      .osc_keep_em4(osc_keep_em4), .compare_pulse(compare_pulse),
      .overflow_pulse(overflow_pulse), .crystal_failure_flag(crystal_failure_flag),
      .ram_powered_down(ram_powered_down)
   );

   initial begin
      core_clk = 1'b0;
      forever #20 core_clk = ~core_clk;
   end

   always @(posedge core_clk) begin
      if (compare_pulse === 1'b1) n_cmp++;
      if (overflow_pulse === 1'b1) n_of++;
   end

   task automatic tally_and_finish;
      $display("checks %0d mismatches %0d", samples_checked, n_fail);
      if (n_fail == 0 && samples_checked > 0) $display("verification passed");
      else $display("verification failed");
      $finish;
   endtask

   task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
      samples_checked++;
      if (exp !== got) begin
         n_fail++;
         $display("MISMATCH %s expected %h seen %h", what, exp, got);
      end
   endtask

   task automatic wr(input logic [7:0] a, input logic [31:0] d);
      @(posedge core_clk);
      wr_en <= 1'b1;
      addr  <= a;
      wdata <= d;
      @(posedge core_clk);
      wr_en <= 1'b0;
   endtask

   task automatic rd(input logic [7:0] a, output logic [31:0] d);
      @(posedge core_clk);
      rd_en <= 1'b1;
      addr  <= a;
      @(posedge core_clk);
      rd_en <= 1'b0;
      #1;
      d = rdata;
   endtask

   task automatic rd_chk(input string what, input logic [7:0] a, input logic [31:0] exp);
      logic [31:0] d;
      rd(a, d);
      chk(what, exp, d);
   endtask

   task automatic ticks(input int n);
      repeat (n) begin
         @(posedge core_clk);
         rc_tick <= 1'b1;
         @(posedge core_clk);
         rc_tick <= 1'b0;
      end
   endtask

   initial begin
      #400000;
      n_fail++;
      tally_and_finish();
   end

   initial begin
      rst_n = 1'b0; addr = 8'h00; wdata = 32'h0; wr_en = 1'b0; rd_en = 1'b0;
      rc_tick = 1'b0; xtal_tick = 1'b0; ulf_tick = 1'b0; debug_halt = 1'b0;
      backup_mode = 1'b0; ram_write_busy = 1'b0; energy_mode = 3'h0;
      n_fail = 0; samples_checked = 0; n_cmp = 0; n_of = 0;
      repeat (8) @(posedge core_clk);
      rst_n <= 1'b1;
      // reset values and unmapped read
      rd_chk("ctrl", OFF_CTRL, 32'h00000008);
      rd_chk("lpcfg", OFF_LPCFG, 32'h00000000);
      rd_chk("cnt", OFF_CNT, 32'h00000000);
      rd_chk("comp", OFF_COMP, 32'h00000000);
      rd_chk("stamp", OFF_STAMP, 32'h00000000);
      rd_chk("fdet", OFF_FDET, 32'h00000000);
      rd_chk("status", OFF_STATUS, 32'h00000000);
      rd_chk("pdown", OFF_PDOWN, 32'h00000000);
      rd_chk("unmapped", 8'h30, 32'h00000000);
      // masks and access kinds
      wr(OFF_CTRL, 32'hFFFFFFFF);
      rd_chk("ctrl mask", OFF_CTRL, 32'h000077FF);
      wr(OFF_FDET, 32'hFFFFFFFF);
      rd_chk("fdet mask", OFF_FDET, 32'h000001F3);
      wr(OFF_FDET, 32'h00000000);
      wr(OFF_COMP, 32'hA5C3_5AC3);
      rd_chk("comp rw", OFF_COMP, 32'hA5C35AC3);
      wr(OFF_CNT, 32'h12345678);
      rd_chk("cnt ro", OFF_CNT, 32'h00000000);
      // run mode oscillator holds
      for (int m = 0; m < 4; m++) begin
         wr(OFF_CTRL, 32'h00000008 | m);
         #1;
         chk("keep em3", {31'h0, m >= 2}, {31'h0, osc_keep_em3});
         chk("keep em4", {31'h0, m == 3}, {31'h0, osc_keep_em4});
      end
      // held counter ignores ticks
      wr(OFF_CTRL, 32'h0000100B);
      ticks(4);
      rd_chk("cnt held", OFF_CNT, 32'h00000000);
      // rc source divided by four
      wr(OFF_CTRL, 32'h00001203);
      ticks(12);
      rd_chk("cnt div4", OFF_CNT, 32'h00000003);
      debug_halt <= 1'b1;
      ticks(8);
      rd_chk("cnt halted", OFF_CNT, 32'h00000003);
      wr(OFF_CTRL, 32'h00001207);
      ticks(4);
      debug_halt <= 1'b0;
      rd_chk("cnt dbg run", OFF_CNT, 32'h00000004);
      // compare as wrap point
      wr(OFF_CTRL, 32'h0000100B);
      wr(OFF_COMP, 32'h00000003);
      wr(OFF_CTRL, 32'h00001013);
      n_cmp = 0;
      ticks(9);
      rd(OFF_CNT, v);
      chk("cnt wrapped", 32'h00000001, v);
      chk("compare count", 32'h00000002, n_cmp);
      // stamp and ram write error on backup entry
      wr(OFF_CTRL, 32'h0000100B);
      wr(OFF_CTRL, 32'h00005003);
      ticks(5);
      backup_mode <= 1'b1;
      ram_write_busy <= 1'b1;
      ticks(3);
      rd_chk("status stamped", OFF_STATUS, 32'h00000006);
      rd(OFF_STAMP, v);
      chk("stamp value", 32'h1, {31'h0, v >= 32'h6 && v <= 32'h7});
      backup_mode <= 1'b0;
      ram_write_busy <= 1'b0;
      wr(OFF_CMD, 32'h00000001);
      rd_chk("status cleared", OFF_STATUS, 32'h00000000);
      wr(OFF_CTRL, 32'h0000500B);
      rd_chk("stamp held", OFF_STAMP, 32'h00000000);
      // low power selections
      wr(OFF_CTRL, 32'h00001003);
      wr(OFF_LPCFG, 32'h00000001);
      rd_chk("lp on", OFF_STATUS, 32'h00000001);
      wr(OFF_LPCFG, 32'h00000002);
      rd_chk("lp backup idle", OFF_STATUS, 32'h00000000);
      backup_mode <= 1'b1;
      ticks(1);
      rd_chk("lp backup on", OFF_STATUS, 32'h00000001);
      backup_mode <= 1'b0;
      wr(OFF_LPCFG, 32'h00000000);
      // low power compare masking and energy-mode gating
      wr(OFF_CTRL, 32'h0000104B);
      wr(OFF_COMP, 32'h00000005);
      wr(OFF_LPCFG, 32'h00000001);
      n_cmp = 0;
      wr(OFF_CTRL, 32'h00001043);
      ticks(8);
      rd_chk("cnt lp run", OFF_CNT, 32'h00000008);
      chk("lp compare count", 32'h00000004, n_cmp);
      energy_mode <= 3'h3;
      wr(OFF_CTRL, 32'h00001041);
      ticks(2);
      rd_chk("cnt em3 stop", OFF_CNT, 32'h00000008);
      wr(OFF_CTRL, 32'h00001042);
      ticks(2);
      rd_chk("cnt em3 run", OFF_CNT, 32'h0000000A);
      energy_mode <= 3'h0;
      wr(OFF_LPCFG, 32'h00000000);
      // one-way ram power-down
      wr(OFF_PDOWN, 32'h00000001);
      wr(OFF_PDOWN, 32'h00000000);
      rd_chk("pdown", OFF_PDOWN, 32'h00000001);
      chk("ram off", 32'h1, {31'h0, ram_powered_down});
      // crystal selected but silent
      wr(OFF_FDET, 32'h00000021);
      wr(OFF_CTRL, 32'h00002003);
      ticks(2);
      chk("xtal early", 32'h0, {31'h0, crystal_failure_flag});
      ticks(38);
      chk("xtal fail", 32'h1, {31'h0, crystal_failure_flag});
      rd_chk("events", OFF_EVENTS, 32'h00000001);
      chk("overflow none", 32'h00000000, n_of);
      tally_and_finish();
   end
endmodule
